// *** mac_debug_irq_addr_filter_tb.sv ***
`timescale 1ns/1ps
`include "mdiaf_cfg.svh"
module mac_debug_irq_addr_filter_tb;
  import mdiaf_pkg::*;
  // ----
  // Signals.
  // ----
  logic          ref_clk, rst_b, regWr, regRd, ptp, fv, fm, acc, sch, irq;
  logic [15:0]   regAddr;
  mdiaf_word_t   regWrData, regRdData;
  logic [12:0]   ev;
  mdiaf_dbg_s    dbg, d;
  mdiaf_rxaddr_s rxa;
  logic [2:0]    fh;
  logic [1:0]    c;
  logic [47:0]   psa, a2;
  int            n_errors, n_checks, cycN;
  logic [15:0]   regs [9] = '{`MDIAF_OFS_DEBUG, `MDIAF_OFS_IRQ_STAT, `MDIAF_OFS_IRQ_MASK,
    `MDIAF_OFS_ST0_UP, `MDIAF_OFS_ST0_LO, `MDIAF_OFS_F1_UP, `MDIAF_OFS_F1_LO,
    `MDIAF_OFS_F2_UP, `MDIAF_OFS_F2_LO};
  mdiaf_top i_dut (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .dbgIn(dbg), .ptpEnable(ptp), .evtIn(mdiaf_evt_s'(ev)), .rxAddrIn(rxa),
    .filtValid(fv), .filtHit(fh), .filtMatch(fm), .txFrameAccept(acc),
    .txScheduleOk(sch), .pauseSrcAddr(psa), .irqOut(irq));
  mdiaf_peer i_peer (.ref_clk(ref_clk), .dbg(dbg), .rxAddr(rxa));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // ----
  // Tasks.
  // ----
  task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [15:0] a, input mdiaf_word_t v);
    @(posedge ref_clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= v;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  // Read data stand only in the cycle after the strobe, so sample there.
  task automatic rc(input logic [15:0] a, input mdiaf_word_t e);
    @(posedge ref_clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1;
    chk($sformatf("reg %h", a), regRdData, e);
  endtask : rc
  // Event pulses are one cycle; the flag lands, then the output a cycle later.
  task automatic pulse(input int b);
    @(posedge ref_clk);
    ev[b] <= 1'b1;
    @(posedge ref_clk);
    ev[b] <= 1'b0;
    cyc(1);
  endtask : pulse
  task automatic irqc(input mdiaf_word_t e, input logic i);
    chk("irqOut", irq, i);
    rc(`MDIAF_OFS_IRQ_STAT, e);
  endtask : irqc
  task automatic frm(input logic [47:0] dst, input logic [47:0] src, input logic [2:0] e);
    i_peer.send(dst, src);
    chk("filter", {fv, fm, fh}, {1'b1, |e, e});
  endtask : frm
  function automatic mdiaf_word_t xdbg(input mdiaf_dbg_s v);
    mdiaf_word_t e;
    e = '0;
    e[`MDIAF_DBG_RXENG] = v.rxEngineActive;
    e[`MDIAF_DBG_RXFC_LSB +: 2] = v.rxFrameCtrlFifoBits;
    e[`MDIAF_DBG_RXWR] = v.rxFifoWriterActive;
    e[`MDIAF_DBG_RXRD_LSB +: 2] = v.rxFifoReaderState;
    e[`MDIAF_DBG_RXLVL_LSB +: 2] = v.rxFifoFillLevel;
    e[`MDIAF_DBG_TXENG] = v.txEngineActive;
    e[`MDIAF_DBG_TXFC_LSB +: 2] = v.txFrameCtrlState;
    e[`MDIAF_DBG_TXPAUSE] = v.txPaused;
    e[`MDIAF_DBG_TXRD_LSB +: 2] = v.txFifoReaderState;
    e[`MDIAF_DBG_TXWR] = v.txFifoWriterActive;
    e[`MDIAF_DBG_TXNE] = v.txFifoNotEmpty;
    e[`MDIAF_DBG_TXSFULL] = v.txStatusFifoFull;
    return e;
  endfunction : xdbg
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_sim
  // A hang is cut short well past the few hundred cycles the tests need.
  always @(posedge ref_clk) begin
    cycN++;
    if (cycN == 8000) begin
      n_errors++;
      end_sim();
    end
  end
  // ----
  // Tests.
  // ----
  initial begin
    {rst_b, regWr, regRd, ptp, regAddr, regWrData, ev} = '0;
    repeat (2) @(posedge ref_clk);
    rst_b <= 1'b1;
    cyc(3);
    for (int i = 0; i < 9; i++) rc(regs[i], (i == 3) ? 32'h8000_0000 : 32'h0);
    chk("gates", {acc, sch}, 2'b11);
    wr(16'h1058, 32'hFFFF_FFFF);
    rc(16'h1058, 32'h0);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      d = {c[0], c[0], c[0], c, c[0], c, c[0], c, c, c[0], c, c[0]};
      i_peer.set_dbg(d);
      cyc(3);
      rc(`MDIAF_OFS_DEBUG, xdbg(d));
      chk("gates", {acc, sch}, {~c[0], ~c[0]});
    end
    d = '0;
    d.txPaused = 1'b1;
    i_peer.set_dbg(d);
    cyc(3);
    chk("gates", {acc, sch}, 2'b10);
    wr(`MDIAF_OFS_DEBUG, 32'h0);
    rc(`MDIAF_OFS_DEBUG, xdbg(d));
    $display("debug test done");
    @(posedge ref_clk);
    ptp <= 1'b1;
    ev[12] <= 1'b1;
    pulse(11);
    irqc(32'h400, 1'b1);
    wr(`MDIAF_OFS_IRQ_MASK, 32'h400);
    cyc(2);
    chk("irqOut", irq, 1'b0);
    rc(`MDIAF_OFS_IRQ_MASK, 32'h400);
    pulse(9);
    irqc(32'h0, 1'b0);
    wr(`MDIAF_OFS_IRQ_MASK, 32'h0);
    ev[12] <= 1'b0;
    pulse(10);
    irqc(32'h0, 1'b0);
    for (int b = 5; b < 8; b++) begin
      pulse(b);
      irqc(32'h200, 1'b1);
      pulse(4);
      irqc(32'h0, 1'b0);
    end
    @(posedge ref_clk);
    ev[8] <= 1'b1;
    pulse(6);
    irqc(32'h0, 1'b0);
    pulse(7);
    irqc(32'h200, 1'b1);
    cyc(2);
    irqc(32'h0, 1'b0);
    @(posedge ref_clk);
    ptp <= 1'b0;
    wr(`MDIAF_OFS_IRQ_MASK, 32'h200);
    rc(`MDIAF_OFS_IRQ_MASK, 32'h0);
    pulse(7);
    chk("irqOut", irq, 1'b1);
    @(posedge ref_clk);
    ptp <= 1'b1;
    wr(`MDIAF_OFS_IRQ_MASK, 32'h200);
    cyc(2);
    chk("irqOut", irq, 1'b0);
    rc(`MDIAF_OFS_IRQ_STAT, 32'h200);
    wr(`MDIAF_OFS_IRQ_MASK, 32'h0);
    ev[8] <= 1'b0;
    pulse(3);
    irqc(32'h0, 1'b0);
    @(posedge ref_clk);
    ev[1] <= 1'b1;
    for (int b = 2; b < 4; b++) begin
      pulse(b);
      irqc(32'h8, 1'b1);
      pulse(0);
      irqc(32'h0, 1'b0);
    end
    $display("interrupt test done");
    wr(`MDIAF_OFS_ST0_UP, 32'h0000_1A2B);
    wr(`MDIAF_OFS_ST0_LO, 32'h3C4D_5E6F);
    cyc(2);
    chk("pauseSrcAddr", psa, 48'h1A2B_3C4D_5E6F);
    rc(`MDIAF_OFS_ST0_UP, 32'h8000_1A2B);
    frm(48'h1A2B_3C4D_5E6F, 48'h1, 3'b001);
    wr(`MDIAF_OFS_F1_UP, 32'hC000_0102);
    wr(`MDIAF_OFS_F1_LO, 32'h0304_0506);
    frm(48'h1, 48'h0102_0304_0506, 3'b010);
    frm(48'h0102_0304_0506, 48'h1, 3'b000);
    wr(`MDIAF_OFS_F1_UP, 32'h4000_0102);
    frm(48'h1, 48'h0102_0304_0506, 3'b000);
    wr(`MDIAF_OFS_F2_LO, 32'h0C0D_0E0F);
    a2 = 48'h0A0B_0C0D_0E0F;
    for (int i = 0; i < 6; i++) begin
      wr(`MDIAF_OFS_F2_UP, 32'h8000_0A0B | (32'h1 << (24 + i)));
      frm(a2 ^ (48'hFF << (8 * i)), 48'h1, 3'b100);
    end
    wr(`MDIAF_OFS_F2_UP, 32'h8000_0A0B);
    rc(`MDIAF_OFS_F2_UP, 32'h8000_0A0B);
    frm(a2 ^ 48'hFF, 48'h1, 3'b000);
    frm(a2, 48'h1, 3'b100);
    $display("filter test done");
    end_sim();
  end
endmodule : mac_debug_irq_addr_filter_tb

// *** mdiaf_cfg.svh ***
`ifndef MDIAF_CFG_SVH
`define MDIAF_CFG_SVH

// ------------------------------------------------------------
// Register offsets (byte addresses on the plain port).
// ------------------------------------------------------------
`define MDIAF_ADDR_W        16
`define MDIAF_OFS_DEBUG     16'h1024
`define MDIAF_OFS_IRQ_STAT  16'h1038
`define MDIAF_OFS_IRQ_MASK  16'h103C
`define MDIAF_OFS_ST0_UP    16'h1040
`define MDIAF_OFS_ST0_LO    16'h1044
`define MDIAF_OFS_F1_UP     16'h1048
`define MDIAF_OFS_F1_LO     16'h104C
`define MDIAF_OFS_F2_UP     16'h1050
`define MDIAF_OFS_F2_LO     16'h1054

// ------------------------------------------------------------
// Debug register field positions.
// ------------------------------------------------------------
`define MDIAF_DBG_RXENG     0
`define MDIAF_DBG_RXFC_LSB  1
`define MDIAF_DBG_RXWR      4
`define MDIAF_DBG_RXRD_LSB  5
`define MDIAF_DBG_RXLVL_LSB 8
`define MDIAF_DBG_TXENG     16
`define MDIAF_DBG_TXFC_LSB  17
`define MDIAF_DBG_TXPAUSE   19
`define MDIAF_DBG_TXRD_LSB  20
`define MDIAF_DBG_TXWR      22
`define MDIAF_DBG_TXNE      24
`define MDIAF_DBG_TXSFULL   25

// ------------------------------------------------------------
// Interrupt status and mask bit positions.
// ------------------------------------------------------------
`define MDIAF_IRQ_WAKE      3
`define MDIAF_IRQ_TS        9
`define MDIAF_IRQ_LPI       10

// ------------------------------------------------------------
// Address entry upper word layout.
// ------------------------------------------------------------
`define MDIAF_ENT_VALID     31
`define MDIAF_ENT_SA        30
`define MDIAF_ENT_MSK_HI    29
`define MDIAF_ENT_MSK_LO    24
`define MDIAF_ENT_ADDR_HI   15
`define MDIAF_ENT_ADDR_LO   0
`define MDIAF_ENT_MSK_W     6
`define MDIAF_ENT_NUM       3

// ------------------------------------------------------------
// Reset values.
// ------------------------------------------------------------
`define MDIAF_RST_WORD      32'h0000_0000
`define MDIAF_RST_ADDR48    48'h0000_0000_0000

`endif

// *** mdiaf_peer.sv ***
`timescale 1ns/1ps
module mdiaf_peer (
  // Clock.
  input wire logic                ref_clk,
  // Path state and received addresses.
  output mdiaf_pkg::mdiaf_dbg_s    dbg,
  output mdiaf_pkg::mdiaf_rxaddr_s rxAddr
);
  import mdiaf_pkg::*;
  // Idle values at time zero.
  initial begin
    dbg = '0;
    rxAddr = '0;
  end
  // New path state lands just after an edge.
  task automatic set_dbg(input mdiaf_dbg_s v);
    @(posedge ref_clk);
    dbg <= v;
  endtask : set_dbg
  // One address pair; afterwards the fields show the inverse, not stale data.
  task automatic send(input logic [47:0] dst, input logic [47:0] src);
    @(posedge ref_clk);
    rxAddr <= '{1'b1, dst, src};
    @(posedge ref_clk);
    rxAddr <= '{1'b0, ~dst, ~src};
    #1;
  endtask : send
endmodule : mdiaf_peer

// *** mdiaf_pkg.sv ***
package mdiaf_pkg;

  // Raw debug state collected from the transmit and receive paths.
  typedef struct packed {
    logic       txStatusFifoFull;
    logic       txFifoNotEmpty;
    logic       txFifoWriterActive;
    logic [1:0] txFifoReaderState;
    logic       txPaused;
    logic [1:0] txFrameCtrlState;
    logic       txEngineActive;
    logic [1:0] rxFifoFillLevel;
    logic [1:0] rxFifoReaderState;
    logic       rxFifoWriterActive;
    logic [1:0] rxFrameCtrlFifoBits;
    logic       rxEngineActive;
  } mdiaf_dbg_s;

  // Interrupt source events and side-register read pulses.
  typedef struct packed {
    logic eeeEnable;
    logic lpiTxChange;
    logic lpiRxChange;
    logic lpiCtrlRead;
    logic tsDefaultMode;
    logic tsTargetReached;
    logic tsSecondsOvf;
    logic tsAuxSnapshot;
    logic tsStatusRead;
    logic wakeMagic;
    logic wakeFrame;
    logic powerDown;
    logic wakeFlagsCleared;
  } mdiaf_evt_s;

  // Received frame address fields offered to the filter.
  typedef struct packed {
    logic        valid;
    logic [47:0] dstAddr;
    logic [47:0] srcAddr;
  } mdiaf_rxaddr_s;

  // Entry layout as one record.
  typedef struct packed {
    logic        valid;
    logic        cmpSrc;
    logic [5:0]  byteSkip;
    logic [47:0] addr;
  } mdiaf_entry_s;

  typedef logic [31:0] mdiaf_word_t;

endpackage : mdiaf_pkg

// *** mdiaf_top.sv ***
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`include "mdiaf_cfg.svh"
module mdiaf_top (
  // Clock and reset.
  input  wire logic                   ref_clk,
  input  wire logic                   rst_b,
  // Register port.
  input  wire logic [15:0]            regAddr,
  input  wire mdiaf_pkg::mdiaf_word_t regWrData,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output      mdiaf_pkg::mdiaf_word_t regRdData,
  // Internal state of the MAC paths.
  input  wire mdiaf_pkg::mdiaf_dbg_s  dbgIn,
  input  wire logic                   ptpEnable,
  // Interrupt sources.
  input  wire mdiaf_pkg::mdiaf_evt_s  evtIn,
  // Receive address filter.
  input  wire mdiaf_pkg::mdiaf_rxaddr_s rxAddrIn,
  output      logic                   filtValid,
  output      logic [2:0]             filtHit,
  output      logic                   filtMatch,
  // Transmit gating and pause source address.
  output      logic                   txFrameAccept,
  output      logic                   txScheduleOk,
  output      logic [47:0]            pauseSrcAddr,
  // Interrupt output.
  output      logic                   irqOut
);
  import mdiaf_pkg::*;

  // ----------------------------------------------------------
  // Storage.
  // ----------------------------------------------------------
  mdiaf_dbg_s  dbgState;          // Captured debug state.
  logic        lpiFlag;           // Low-power-idle status.
  logic        tsFlag;            // Timestamp status.
  logic        wakeFlag;          // Wake status.
  logic        lpiBlock;          // Mask for low-power-idle.
  logic        tsBlock;           // Mask for timestamp.
  logic        wakeBlock;         // Mask for wake.
  logic [47:0] stationAddr;       // Primary station address.
  mdiaf_entry_s entry [1:2];      // Extra filter entries.
  logic [31:0] next_regRdData;    // Read mux result.
  logic [2:0]  next_hit;          // Filter compare result.
  logic        tsReadPend;        // Status read in flight.

  // ----------------------------------------------------------
  // Helpers.
  // ----------------------------------------------------------

  // Address decode, used by both the write and read paths.
  function automatic logic hitOfs(input logic [15:0] a,
                                  input logic [15:0] ofs);
    hitOfs = (a == ofs);
  endfunction : hitOfs

  // Byte-masked compare; skip bit 5 covers bits 47:40, bit 0
  // covers bits 7:0, so the layout follows the register.
  function automatic logic cmpMasked(input logic [47:0] a,
                                     input logic [47:0] b,
                                     input logic [5:0]  skip);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 6; i++) begin
      if (!skip[i] && (a[i*8 +: 8] != b[i*8 +: 8])) begin
        ok = 1'b0;
      end
    end
    cmpMasked = ok;
  endfunction : cmpMasked

  // Pack one entry's upper word for read back.
  function automatic logic [31:0] entUpper(input mdiaf_entry_s e);
    logic [31:0] w;
    w = `MDIAF_RST_WORD;
    w[`MDIAF_ENT_VALID] = e.valid;
    w[`MDIAF_ENT_SA]    = e.cmpSrc;
    w[`MDIAF_ENT_MSK_HI:`MDIAF_ENT_MSK_LO] = e.byteSkip;
    w[`MDIAF_ENT_ADDR_HI:`MDIAF_ENT_ADDR_LO] = e.addr[47:32];
    entUpper = w;
  endfunction : entUpper

  // ----------------------------------------------------------
  // Debug state capture.
  // ----------------------------------------------------------

  // The status inputs are sampled every cycle; they come from
  // logic on this clock, so no synchroniser is needed.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      dbgState <= '0;
    end else begin
      dbgState <= dbgIn;
    end
  end

  // ----------------------------------------------------------
  // Transmit gating.
  // ----------------------------------------------------------

  // A full status FIFO refuses frames; a pause also stops
  // scheduling. Both come from the captured state, so the
  // gates and the readable flags agree, except in reset, which closes both gates.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      txFrameAccept <= 1'b0;
      txScheduleOk  <= 1'b0;
    end else begin
      txFrameAccept <= !dbgState.txStatusFifoFull;
      txScheduleOk  <= !dbgState.txStatusFifoFull &&
                       !dbgState.txPaused;
    end
  end

  // ----------------------------------------------------------
  // Interrupt status flags.
  // ----------------------------------------------------------

  // Low-power-idle flag. A change in the same cycle as the
  // clearing read wins, so no event is lost.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lpiFlag <= 1'b0;
    end else if (evtIn.eeeEnable &&
                 (evtIn.lpiTxChange || evtIn.lpiRxChange)) begin
      lpiFlag <= 1'b1;
    end else if (evtIn.lpiCtrlRead) begin
      lpiFlag <= 1'b0;
    end
  end

  // Remember that this block's status register was read while
  // the timestamp flag was up; clearing waits until the read
  // data has been returned so the read shows the set bit.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tsReadPend <= 1'b0;
    end else begin
      tsReadPend <= regRd && tsFlag && evtIn.tsDefaultMode &&
                    hitOfs(regAddr, `MDIAF_OFS_IRQ_STAT);
    end
  end

  // Timestamp flag. Default mode only honours the target time
  // and clears after its own read; otherwise all three causes
  // set it and the timestamp status read clears it.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      tsFlag <= 1'b0;
    end else if (evtIn.tsDefaultMode) begin
      if (evtIn.tsTargetReached) begin
        tsFlag <= 1'b1;
      end else if (tsReadPend) begin
        tsFlag <= 1'b0;
      end
    end else begin
      if (evtIn.tsTargetReached || evtIn.tsSecondsOvf ||
          evtIn.tsAuxSnapshot) begin
        tsFlag <= 1'b1;
      end else if (evtIn.tsStatusRead) begin
        tsFlag <= 1'b0;
      end
    end
  end

  // Wake flag, only while powered down; cleared when the
  // power-management read has cleared both wake flags.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      wakeFlag <= 1'b0;
    end else if (evtIn.powerDown &&
                 (evtIn.wakeMagic || evtIn.wakeFrame)) begin
      wakeFlag <= 1'b1;
    end else if (evtIn.wakeFlagsCleared) begin
      wakeFlag <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Interrupt masks.
  // ----------------------------------------------------------

  // Mask bits are plain storage; the timestamp bit reads back only with ptpEnable.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lpiBlock  <= 1'b0;
      tsBlock   <= 1'b0;
      wakeBlock <= 1'b0;
    end else if (regWr && hitOfs(regAddr, `MDIAF_OFS_IRQ_MASK)) begin
      lpiBlock  <= regWrData[`MDIAF_IRQ_LPI];
      tsBlock   <= regWrData[`MDIAF_IRQ_TS];
      wakeBlock <= regWrData[`MDIAF_IRQ_WAKE];
    end
  end

  // ----------------------------------------------------------
  // Interrupt output.
  // ----------------------------------------------------------

  // The timestamp mask only counts with timestamping on; when
  // it is off the bit is reserved and has no effect.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      irqOut <= 1'b0;
    end else begin
      irqOut <= (lpiFlag && !lpiBlock) ||
                (tsFlag && !(tsBlock && ptpEnable)) ||
                (wakeFlag && !wakeBlock);
    end
  end

  // ----------------------------------------------------------
  // Address entries.
  // ----------------------------------------------------------

  // Primary station address; it has no enable to write, the
  // enable reads as one.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stationAddr <= `MDIAF_RST_ADDR48;
    end else if (regWr && hitOfs(regAddr, `MDIAF_OFS_ST0_UP)) begin
      stationAddr[47:32] <=
        regWrData[`MDIAF_ENT_ADDR_HI:`MDIAF_ENT_ADDR_LO];
    end else if (regWr && hitOfs(regAddr, `MDIAF_OFS_ST0_LO)) begin
      stationAddr[31:0] <= regWrData;
    end
  end

  // Pause frames carry the station address as source.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pauseSrcAddr <= `MDIAF_RST_ADDR48;
    end else begin
      pauseSrcAddr <= stationAddr;
    end
  end

  // Extra entries. The lower word is reset to zero only to
  // keep simulation defined; software must still program it.
  for (genvar g = 1; g <= 2; g++) begin : gEntry
    localparam logic [15:0] UP_OFS =
      (g == 1) ? `MDIAF_OFS_F1_UP : `MDIAF_OFS_F2_UP;
    localparam logic [15:0] LO_OFS =
      (g == 1) ? `MDIAF_OFS_F1_LO : `MDIAF_OFS_F2_LO;

    // Upper word holds control, byte skips and address top.
    always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
        entry[g] <= '0;
      end else if (regWr && hitOfs(regAddr, UP_OFS)) begin
        entry[g].valid    <= regWrData[`MDIAF_ENT_VALID];
        entry[g].cmpSrc   <= regWrData[`MDIAF_ENT_SA];
        entry[g].byteSkip <=
          regWrData[`MDIAF_ENT_MSK_HI:`MDIAF_ENT_MSK_LO];
        entry[g].addr[47:32] <=
          regWrData[`MDIAF_ENT_ADDR_HI:`MDIAF_ENT_ADDR_LO];
      end else if (regWr && hitOfs(regAddr, LO_OFS)) begin
        entry[g].addr[31:0] <= regWrData;
      end
    end

    // Compare: select picks the field, skips drop bytes.
    always_comb begin
      next_hit[g] = entry[g].valid &&
        cmpMasked(entry[g].cmpSrc ? rxAddrIn.srcAddr
                                  : rxAddrIn.dstAddr,
                  entry[g].addr, entry[g].byteSkip);
    end
  end

  // The primary entry always takes part, on destination.
  always_comb begin
    next_hit[0] = (rxAddrIn.dstAddr == stationAddr);
  end

  // ----------------------------------------------------------
  // Filter result.
  // ----------------------------------------------------------

  // One cycle from offered address to registered verdict.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      filtValid <= 1'b0;
      filtHit   <= 3'h0;
      filtMatch <= 1'b0;
    end else begin
      filtValid <= rxAddrIn.valid;
      filtHit   <= rxAddrIn.valid ? next_hit : 3'h0;
      filtMatch <= rxAddrIn.valid && (|next_hit);
    end
  end

  // ----------------------------------------------------------
  // Read path.
  // ----------------------------------------------------------

  // Unmapped offsets read as zero; reserved bits read zero.
  always_comb begin
    next_regRdData = `MDIAF_RST_WORD;
    case (regAddr)
      `MDIAF_OFS_DEBUG: begin
        next_regRdData[`MDIAF_DBG_RXENG] =
          dbgState.rxEngineActive;
        next_regRdData[`MDIAF_DBG_RXFC_LSB +: 2] =
          dbgState.rxFrameCtrlFifoBits;
        next_regRdData[`MDIAF_DBG_RXWR] =
          dbgState.rxFifoWriterActive;
        next_regRdData[`MDIAF_DBG_RXRD_LSB +: 2] =
          dbgState.rxFifoReaderState;
        next_regRdData[`MDIAF_DBG_RXLVL_LSB +: 2] =
          dbgState.rxFifoFillLevel;
        next_regRdData[`MDIAF_DBG_TXENG] =
          dbgState.txEngineActive;
        next_regRdData[`MDIAF_DBG_TXFC_LSB +: 2] =
          dbgState.txFrameCtrlState;
        next_regRdData[`MDIAF_DBG_TXPAUSE] =
          dbgState.txPaused;
        next_regRdData[`MDIAF_DBG_TXRD_LSB +: 2] =
          dbgState.txFifoReaderState;
        next_regRdData[`MDIAF_DBG_TXWR] =
          dbgState.txFifoWriterActive;
        next_regRdData[`MDIAF_DBG_TXNE] =
          dbgState.txFifoNotEmpty;
        next_regRdData[`MDIAF_DBG_TXSFULL] =
          dbgState.txStatusFifoFull;
      end
      `MDIAF_OFS_IRQ_STAT: begin
        next_regRdData[`MDIAF_IRQ_LPI]  = lpiFlag;
        next_regRdData[`MDIAF_IRQ_TS]   = tsFlag;
        next_regRdData[`MDIAF_IRQ_WAKE] = wakeFlag;
      end
      `MDIAF_OFS_IRQ_MASK: begin
        next_regRdData[`MDIAF_IRQ_LPI]  = lpiBlock;
        next_regRdData[`MDIAF_IRQ_TS]   = tsBlock && ptpEnable;
        next_regRdData[`MDIAF_IRQ_WAKE] = wakeBlock;
      end
      `MDIAF_OFS_ST0_UP: begin
        next_regRdData[`MDIAF_ENT_VALID] = 1'b1;
        next_regRdData[`MDIAF_ENT_ADDR_HI:`MDIAF_ENT_ADDR_LO] =
          stationAddr[47:32];
      end
      `MDIAF_OFS_ST0_LO: begin
        next_regRdData = stationAddr[31:0];
      end
      `MDIAF_OFS_F1_UP: begin
        next_regRdData = entUpper(entry[1]);
      end
      `MDIAF_OFS_F1_LO: begin
        next_regRdData = entry[1].addr[31:0];
      end
      `MDIAF_OFS_F2_UP: begin
        next_regRdData = entUpper(entry[2]);
      end
      `MDIAF_OFS_F2_LO: begin
        next_regRdData = entry[2].addr[31:0];
      end
      default: begin
        next_regRdData = `MDIAF_RST_WORD;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      regRdData <= `MDIAF_RST_WORD;
    end else if (regRd) begin
      regRdData <= next_regRdData;
    end else begin
      regRdData <= `MDIAF_RST_WORD;
    end
  end

endmodule : mdiaf_top

// *** mdiaf_top_sva.sv ***
`timescale 1ns/1ps
`include "mdiaf_cfg.svh"
module mdiaf_top_sva (
  // Clock and reset.
  input wire logic                     ref_clk,
  input wire logic                     rst_b,
  // Register port.
  input wire logic [15:0]              regAddr,
  input wire mdiaf_pkg::mdiaf_word_t   regWrData,
  input wire logic                     regWr,
  input wire logic                     regRd,
  input wire mdiaf_pkg::mdiaf_word_t   regRdData,
  // Path state and events.
  input wire mdiaf_pkg::mdiaf_dbg_s    dbgIn,
  input wire logic                     ptpEnable,
  input wire mdiaf_pkg::mdiaf_evt_s    evtIn,
  // Filter, gates, pause source and interrupt.
  input wire mdiaf_pkg::mdiaf_rxaddr_s rxAddrIn,
  input wire logic                     filtValid,
  input wire logic [2:0]               filtHit,
  input wire logic                     filtMatch,
  input wire logic                     txFrameAccept,
  input wire logic                     txScheduleOk,
  input wire logic [47:0]              pauseSrcAddr,
  input wire logic                     irqOut
);
  import mdiaf_pkg::*;
  // ----
  // Common clock and reset.
  // ----
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // A debug read whose source held still, so the capture lag cannot matter.
  sequence s_dbg_rd;
    regRd && regAddr == `MDIAF_OFS_DEBUG && $stable(dbgIn);
  endsequence
  property p_dbg_rd;
    s_dbg_rd |=> regRdData[`MDIAF_DBG_TXSFULL] == $past(dbgIn.txStatusFifoFull)
      && regRdData[`MDIAF_DBG_RXLVL_LSB +: 2] == $past(dbgIn.rxFifoFillLevel);
  endproperty
  a_dbg_rd: assert property (p_dbg_rd) else $error("debug read mismatch");
  property p_accept;
    $past(dbgIn.txStatusFifoFull, 2) |-> !txFrameAccept;
  endproperty
  a_accept: assert property (p_accept) else $error("frame accepted while full");
  property p_sched;
    $past(dbgIn.txPaused, 2) |-> !txScheduleOk;
  endproperty
  a_sched: assert property (p_sched) else $error("schedule while paused");
  property p_sched_open;
    $past(rst_b, 2) && !$past(dbgIn.txPaused, 2) && !$past(dbgIn.txStatusFifoFull, 2)
      |-> txScheduleOk;
  endproperty
  a_sched_open: assert property (p_sched_open) else $error("schedule gate stuck");
  property p_filt_ack;
    1'b1 |=> filtValid == $past(rxAddrIn.valid);
  endproperty
  a_filt_ack: assert property (p_filt_ack) else $error("filter result lost");
  property p_filt_out;
    filtMatch == (|filtHit) && (filtValid || filtHit == 3'h0);
  endproperty
  a_filt_out: assert property (p_filt_out) else $error("filter hit inconsistent");
  property p_station;
    rxAddrIn.valid && rxAddrIn.dstAddr == pauseSrcAddr && !$past(regWr) |=> filtHit[0];
  endproperty
  a_station: assert property (p_station) else $error("station address missed");
  property p_pause_src;
    !$past(regWr) && !$past(regWr, 2) |-> $stable(pauseSrcAddr);
  endproperty
  a_pause_src: assert property (p_pause_src) else $error("pause source moved");
  property p_st0_en;
    regRd && regAddr == `MDIAF_OFS_ST0_UP |=> regRdData[`MDIAF_ENT_VALID];
  endproperty
  a_st0_en: assert property (p_st0_en) else $error("station enable not one");
  property p_ts_rsvd;
    regRd && regAddr == `MDIAF_OFS_IRQ_MASK && !ptpEnable |=> !regRdData[`MDIAF_IRQ_TS];
  endproperty
  a_ts_rsvd: assert property (p_ts_rsvd) else $error("reserved mask bit set");
endmodule : mdiaf_top_sva
bind mdiaf_top mdiaf_top_sva i_sva (.ref_clk(ref_clk), .rst_b(rst_b), .regAddr(regAddr),
  .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .dbgIn(dbgIn), .ptpEnable(ptpEnable), .evtIn(evtIn), .rxAddrIn(rxAddrIn),
  .filtValid(filtValid), .filtHit(filtHit), .filtMatch(filtMatch),
  .txFrameAccept(txFrameAccept), .txScheduleOk(txScheduleOk),
  .pauseSrcAddr(pauseSrcAddr), .irqOut(irqOut));
